// ### fcd_regs.svh
// Register offsets, field positions, reset values and timing counts of the flag decoder.
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH

// APB byte addresses of the four registers.
`define FCD_ADDR_CMD     8'h00
`define FCD_ADDR_STATUS  8'h04
`define FCD_ADDR_CTRL    8'h08
`define FCD_ADDR_ARM     8'h0C

// Command byte field positions.
`define FCD_CB_RATE_HI   1
`define FCD_CB_RATE_LO   0
`define FCD_CB_MARK      0
`define FCD_CB_SIDE      1
`define FCD_CB_VERIFY    2
`define FCD_CB_SETTLE    2
`define FCD_CB_HEAD      3
`define FCD_CB_LEN       3
`define FCD_CB_TUPD      4
`define FCD_CB_MULTI     4
`define FCD_OPC_FORCE    4'hD

// Status register bit positions.
`define FCD_ST_BUSY      0
`define FCD_ST_IRQ       1
`define FCD_ST_READY     2
`define FCD_ST_SETTLE    3
`define FCD_ST_REJECT    4

// Control register bit positions and reset value.
`define FCD_CTL_SIDEVAR  0
`define FCD_CTL_SLOWCLK  1
`define FCD_CTL_RST      2'h0

// Reset values of the command latch and the data mark.
`define FCD_CMD_RST      8'h00
`define FCD_DAM_NORMAL   8'hFB
`define FCD_DAM_DELETED  8'hF8
`define FCD_SECTOR_MIN   11'h080

// Settling delay: times in ms, counts derived from the 25 MHz clock.
`define FCD_CLK_HZ       25000000
`define FCD_SETTLE_MS    15
`define FCD_SETTLE_SLOW_MS 30
`define FCD_SETTLE_CYC   ((`FCD_CLK_HZ / 1000) * `FCD_SETTLE_MS)
`define FCD_SETTLE_SLOW_CYC ((`FCD_CLK_HZ / 1000) * `FCD_SETTLE_SLOW_MS)
`define FCD_TMR_W        20

`endif

// ### fcd_pkg.sv
// Types shared by the flag decoder modules.
package fcd_pkg;

  // Sequencer states of the command in hand.
  typedef enum logic [1:0] {
    FCD_IDLE,
    FCD_SETTLE,
    FCD_RUN
  } fcd_exec_e;

  // One command byte.
  typedef logic [7:0] fcd_byte_t;

endpackage

// ### fcd_edge_detect.sv
// Rise and fall detectors for the drive status inputs.
`timescale 1ns/1ns
module fcd_edge_detect (
  // Clock, reset and enable.
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // Watched levels and their edges.
  input  wire logic [1:0] sig,
  output logic      [1:0] rise,
  output logic      [1:0] fall
);

  // One history flop per input; edges are seen only on enabled cycles.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_bit
      logic prev_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_reg <= 1'b0;
        end else if (ce) begin
          prev_reg <= sig[i];
        end
      end
      assign rise[i] = ce & sig[i] & ~prev_reg;
      assign fall[i] = ce & ~sig[i] & prev_reg;
    end
  endgenerate

endmodule // fcd_edge_detect

// ### fcd_settle_timer.sv
// Head settling delay counter.
`timescale 1ns/1ns
`include "fcd_regs.svh"
module fcd_settle_timer (
  // Clock, reset and enable.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // Control.
  input  wire logic                  start,
  input  wire logic                  abort,
  input  wire logic [`FCD_TMR_W-1:0] cycles,
  // Result.
  output logic                       done,
  output logic                       running
);

  logic [`FCD_TMR_W-1:0] cnt_reg;

  // Counts down from the loaded length; done pulses one cycle at the end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (abort) begin
        running <= 1'b0;
      end else if (start) begin
        cnt_reg <= cycles;
        running <= 1'b1;
      end else if (running) begin
        if (cnt_reg <= `FCD_TMR_W'(1)) begin
          running <= 1'b0;
          done    <= 1'b1;
        end
        cnt_reg <= cnt_reg - `FCD_TMR_W'(1);
      end
    end
  end

endmodule // fcd_settle_timer

// ### fcd_flag_decode.sv
// Command byte flag decoder with APB register access and force-interrupt arming.
//
// What this block does
// - Positioning bits 1:0 select step rate.
// - Positioning bit 2 enables destination track verify.
// - Positioning bit 3 loads or unloads head.
// - Step bit 4 enables track register update.
// - Write sector bit 0 picks FB or F8.
// - No-side-output variant: bit 1 enables compare.
// - Side-output variant: bit 1 drives side output.
// - Bit 2 inserts 15 ms (30 ms) settle.
// - Compare variant: bit 3 is expected side.
// - Side variant: bit 3 picks sector length table.
// - Sector bit 4 selects multiple record transfer.
// - Arm 0 interrupts on becoming ready.
// - Arm 1 interrupts on losing ready.
// - Arm 2 interrupts on each index pulse.
// - Arm 3 interrupts immediately.
// - Force interrupt, no flags: terminate silently.
// - Busy while executing; completion interrupts, clears busy.
// - Not ready sector/track command: skip, interrupt.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "fcd_regs.svh"
module fcd_flag_decode #(
  parameter int unsigned SETTLE_CYC      = `FCD_SETTLE_CYC,
  parameter int unsigned SETTLE_SLOW_CYC = `FCD_SETTLE_SLOW_CYC
) (
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Drive and executor inputs.
  input  wire logic        drive_ready,
  input  wire logic        index_pulse,
  input  wire logic [1:0]  id_len_code,
  input  wire logic        cmd_done,
  // Status outputs.
  output logic             busy,
  output logic             intrq,
  output logic             cmd_start,
  output logic             cmd_abort,
  output logic             settle_busy,
  // Decoded flags.
  output logic      [1:0]  step_rate_sel,
  output logic             verify_en,
  output logic             head_load,
  output logic             track_update,
  output logic      [7:0]  data_mark,
  output logic             side_cmp_en,
  output logic             side_cmp_val,
  output logic             side_select_out,
  output logic      [10:0] sector_bytes,
  output logic             multi_record
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  fcd_pkg::fcd_exec_e state_reg;
  fcd_pkg::fcd_exec_e state_next;
  fcd_pkg::fcd_byte_t cmd_reg;
  logic [1:0]         ctrl_reg;
  logic [3:0]         arm_reg;
  logic               reject_reg;
  logic               len_sel_reg;
  logic               settle_done;
  logic               settle_run;
  logic [1:0]         edge_rise;
  logic [1:0]         edge_fall;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode.

  // Setup cycle and completed access; pready is registered, so every access has
  // exactly one cycle in the access phase.
  wire        setup     = psel & ~penable;
  wire        acc       = psel & penable & pready;
  wire        wr_acc    = acc & pwrite;
  wire        rd_acc    = acc & ~pwrite;
  wire        hit_cmd   = (paddr == `FCD_ADDR_CMD);
  wire        hit_stat  = (paddr == `FCD_ADDR_STATUS);
  wire        hit_ctrl  = (paddr == `FCD_ADDR_CTRL);
  wire        hit_arm   = (paddr == `FCD_ADDR_ARM);
  wire        hit_any   = hit_cmd | hit_stat | hit_ctrl | hit_arm;

  // Status word assembled from live state.
  wire [4:0]  stat_bits = {reject_reg, settle_busy, drive_ready, intrq, busy};

  // Read selection; unmapped addresses read zero and answer with pslverr.
  wire [31:0] rd_mux    = hit_cmd  ? {24'h000000, cmd_reg} :
                          hit_stat ? {27'h0000000, stat_bits} :
                          hit_ctrl ? {30'h00000000, ctrl_reg} :
                          hit_arm  ? {28'h0000000, arm_reg} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Command classification of the byte being written.

  wire [7:0]  w        = pwdata[7:0];
  wire        w_force  = (w[7:4] == `FCD_OPC_FORCE);
  wire        w_pos    = ~w[7];
  wire        w_sector = (w[7:6] == 2'b10);
  wire        w_t23    = w[7] & ~w_force;
  wire        w_step   = w_pos & (w[6:5] != 2'b00);
  wire        w_wrsec  = w_sector & w[5];
  wire        sidevar  = ctrl_reg[`FCD_CTL_SIDEVAR];

  // A command is taken only when idle; force interrupt is taken at any time.
  wire        wr_cmd   = wr_acc & hit_cmd;
  wire        cmd_ok   = wr_cmd & (~busy | w_force);
  wire        rej      = cmd_ok & w_t23 & ~drive_ready;
  wire        go       = cmd_ok & ~w_force & ~rej;
  wire        settle_q = w_t23 & w[`FCD_CB_SETTLE];
  wire        abort_q  = cmd_ok & w_force;

  ////////////////////////////////////////////////////////////////////////////////
  // Next values of the decoded flags for an accepted command.

  // Fields that do not belong to the command type go to zero (the data mark to FB), so a stale flag of
  // an earlier command type never reaches the executor.
  wire [1:0]  rate_nx  = w_pos ? w[`FCD_CB_RATE_HI:`FCD_CB_RATE_LO] : 2'b00;
  wire        ver_nx   = w_pos & w[`FCD_CB_VERIFY];
  wire        head_nx  = w_pos & w[`FCD_CB_HEAD];
  wire        tupd_nx  = w_step & w[`FCD_CB_TUPD];
  wire [7:0]  mark_nx  = (w_wrsec & w[`FCD_CB_MARK]) ?
                         `FCD_DAM_DELETED : `FCD_DAM_NORMAL;
  wire        cmpen_nx = w_sector & ~sidevar & w[`FCD_CB_SIDE];
  wire        cmpv_nx  = w_sector & ~sidevar & w[`FCD_CB_LEN];
  wire        len_nx   = w_sector & sidevar & w[`FCD_CB_LEN];
  wire        multi_nx = w_sector & w[`FCD_CB_MULTI];

  // Sector length: table with bit clear is the one-set table rotated by one.
  wire [1:0]  len_sh   = len_sel_reg ? id_len_code : (id_len_code + 2'b01);

  // Settle length depends on the configured input clock speed.
  wire [`FCD_TMR_W-1:0] settle_len = ctrl_reg[`FCD_CTL_SLOWCLK] ?
                                     `FCD_TMR_W'(SETTLE_SLOW_CYC) :
                                     `FCD_TMR_W'(SETTLE_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt sources.

  // Armed conditions fire on drive events, and completion or rejection fires too.
  wire        ev_ready = arm_reg[0] & edge_rise[0];
  wire        ev_lost  = arm_reg[1] & edge_fall[0];
  wire        ev_index = arm_reg[2] & edge_rise[1];
  wire        ev_imm   = abort_q & w[3];
  wire        ev_done  = (state_reg == fcd_pkg::FCD_RUN) & cmd_done & ~abort_q;
  wire        irq_set  = ce & (ev_ready | ev_lost | ev_index | ev_imm | ev_done | rej);
  wire        irq_clr  = (rd_acc & hit_stat) | cmd_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules.

  fcd_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .sig     ({index_pulse, drive_ready}),
    .rise    (edge_rise),
    .fall    (edge_fall)
  );

  fcd_settle_timer u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (go & settle_q),
    .abort   (abort_q),
    .cycles  (settle_len),
    .done    (settle_done),
    .running (settle_run)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer.

  // Settling precedes the run phase; force interrupt ends any phase at once.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fcd_pkg::FCD_IDLE: begin
        if (go) begin
          state_next = settle_q ? fcd_pkg::FCD_SETTLE : fcd_pkg::FCD_RUN;
        end
      end
      fcd_pkg::FCD_SETTLE: begin
        if (settle_done) begin
          state_next = fcd_pkg::FCD_RUN;
        end
      end
      fcd_pkg::FCD_RUN: begin
        if (cmd_done) begin
          state_next = fcd_pkg::FCD_IDLE;
        end
      end
      default: begin
        state_next = fcd_pkg::FCD_IDLE;
      end
    endcase
    if (abort_q) begin
      state_next = fcd_pkg::FCD_IDLE;
    end
  end

  // Sequencer, busy and the one-cycle start and abort strobes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fcd_pkg::FCD_IDLE;
      busy      <= 1'b0;
      cmd_start <= 1'b0;
      cmd_abort <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      busy      <= (state_next != fcd_pkg::FCD_IDLE);
      cmd_start <= (state_next == fcd_pkg::FCD_RUN) & (state_reg != fcd_pkg::FCD_RUN);
      cmd_abort <= abort_q & busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command latch and decoded flags.

  // All flags are captured only on an accepted write and held until the next one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg       <= `FCD_CMD_RST;
      step_rate_sel <= 2'b00;
      verify_en     <= 1'b0;
      head_load     <= 1'b0;
      track_update  <= 1'b0;
      data_mark     <= `FCD_DAM_NORMAL;
      side_cmp_en   <= 1'b0;
      side_cmp_val  <= 1'b0;
      len_sel_reg   <= 1'b0;
      multi_record  <= 1'b0;
    end else if (ce & go) begin
      cmd_reg       <= w;
      step_rate_sel <= rate_nx;
      verify_en     <= ver_nx;
      head_load     <= head_nx;
      track_update  <= tupd_nx;
      data_mark     <= mark_nx;
      side_cmp_en   <= cmpen_nx;
      side_cmp_val  <= cmpv_nx;
      len_sel_reg   <= len_nx;
      multi_record  <= multi_nx;
    end
  end

  // Side output follows bit 1 of accepted sector and track commands, in the side variant only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      side_select_out <= 1'b0;
    end else if (ce & go & w_t23 & sidevar) begin
      side_select_out <= w[`FCD_CB_SIDE];
    end
  end

  // Sector size follows the length code of the ID field currently presented.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_bytes <= `FCD_SECTOR_MIN;
    end else if (ce) begin
      sector_bytes <= `FCD_SECTOR_MIN << len_sh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt line, arms and reject flag.

  // Set wins over clear, so an event in the clearing cycle is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intrq       <= 1'b0;
      arm_reg     <= 4'h0;
      reject_reg  <= 1'b0;
      settle_busy <= 1'b0;
    end else if (ce) begin
      intrq       <= irq_set | (intrq & ~irq_clr);
      settle_busy <= settle_run & ~settle_done & ~abort_q;
      if (cmd_ok) begin
        arm_reg    <= w_force ? w[3:0] : 4'h0;
        reject_reg <= rej;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB response and control register.

  // Answer registered in the setup cycle: the access phase always lasts one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h00000000;
      ctrl_reg <= `FCD_CTL_RST;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
      if (wr_acc & hit_ctrl) begin
        ctrl_reg <= pwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && go && w_pos |=> step_rate_sel == $past(pwdata[1:0]))
    else $error("step rate not taken from command bits 1:0");

  AST_TRACK_UPD: assert property (@(posedge pclk) disable iff (!presetn)
    ce && go && w_pos && !w_step |=> !track_update)
    else $error("track update set for a non-step command");

  AST_MARK: assert property (@(posedge pclk) disable iff (!presetn)
    ce && go && w_wrsec |=>
      data_mark == ($past(pwdata[0]) ? 8'hF8 : 8'hFB))
    else $error("data mark does not follow bit 0");

  AST_SIDE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    ce && go && w_t23 && sidevar |=> side_select_out == $past(pwdata[1]))
    else $error("side output not updated from bit 1");

  AST_SETTLE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && go && settle_q |=> state_reg == fcd_pkg::FCD_SETTLE && busy && !cmd_start)
    else $error("settle phase not entered");

  AST_NOT_READY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rej |=> intrq && !busy && state_reg == fcd_pkg::FCD_IDLE)
    else $error("not ready command was started");

  AST_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ev_done |=> !busy && intrq)
    else $error("completion did not clear busy and interrupt");

  AST_SILENT_END: assert property (@(posedge pclk) disable iff (!presetn)
    ce && abort_q && w[3:0] == 4'h0 |=> !busy ##1 arm_reg == 4'h0)
    else $error("silent terminate left busy or arms");

  AST_INDEX: assert property (@(posedge pclk) disable iff (!presetn)
    ce && $past(ce) && arm_reg[2] && index_pulse && !$past(index_pulse) |=> intrq)
    else $error("index pulse did not interrupt");

endmodule // fcd_flag_decode

// ### fcd_host_model.sv
// Host processor model: APB master that writes commands and reads the flag decoder registers.
`timescale 1ns/1ns
module fcd_host_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Device status seen by the host.
  input  wire logic        busy
);
  logic [31:0] rd_data;
  logic        rd_err;

  // The bus is idle at time zero.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
  end

  // One transfer; the request stands until pready is seen high at an edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait length is assumed; only the bench's cycle limit ends a stuck access.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so a stale value is never mistaken for a live one.
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // Command write; waits for idle first unless it is a force interrupt.
  task automatic cmd(input logic [7:0] b);
    while (busy === 1'b1 && b[7:4] != 4'hD) begin
      @(posedge pclk);
    end
    xfer(1'b1, 8'h00, {24'h000000, b});
  endtask
endmodule // fcd_host_model

// ### tb_top.sv
// Self-checking testbench of the command flag decoder.
`timescale 1ns/1ns
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        drive_ready = 1'b1;
  logic        index_pulse = 1'b0;
  logic [1:0]  id_len_code = 2'h0;
  logic        cmd_done = 1'b0;
  logic        ce = 1'b1;
  logic        busy, intrq, cmd_start, cmd_abort, settle_busy;
  logic [1:0]  step_rate_sel;
  logic        verify_en, head_load, track_update, side_cmp_en, side_cmp_val;
  logic        side_select_out, multi_record;
  logic [7:0]  data_mark;
  logic [10:0] sector_bytes;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // A 25 MHz clock.
  always #20 pclk = ~pclk;

  // Short settle counts keep the run brief; expectations use the same figures.
  fcd_flag_decode #(.SETTLE_CYC(20), .SETTLE_SLOW_CYC(40)) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_ready(drive_ready), .index_pulse(index_pulse),
    .id_len_code(id_len_code), .cmd_done(cmd_done), .busy(busy), .intrq(intrq),
    .cmd_start(cmd_start), .cmd_abort(cmd_abort), .settle_busy(settle_busy),
    .step_rate_sel(step_rate_sel), .verify_en(verify_en), .head_load(head_load),
    .track_update(track_update), .data_mark(data_mark), .side_cmp_en(side_cmp_en),
    .side_cmp_val(side_cmp_val), .side_select_out(side_select_out),
    .sector_bytes(sector_bytes), .multi_record(multi_record));

  fcd_host_model host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, report and helpers.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h00000000);
  endtask

  // Executor completion: busy drops and the interrupt is raised.
  task automatic done_cmd();
    @(posedge pclk);
    cmd_done <= 1'b1;
    @(posedge pclk);
    cmd_done <= 1'b0;
    #1;
    check(busy, 1'b0);
    check(intrq, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    check(data_mark, 8'hFB);
    check(sector_bytes, 11'h100);
    check({busy, intrq}, 2'h0);
    rd(8'h08);
    check(host.rd_err, 1'b0);
    check(host.rd_data, 32'h00000000);
    rd(8'h10);
    check(host.rd_err, 1'b1);
    check(host.rd_data, 32'h00000000);
    host.xfer(1'b1, 8'h14, 32'h00000010);
    tick(1);
    check(busy, 1'b0);
  endtask

  // Positioning flags; a write while busy must not disturb them.
  task automatic t_position();
    logic [23:0] cs;
    logic [14:0] es;
    cs = 24'h1F3558;
    es = {5'b01111, 5'b10101, 5'b11000};
    for (int i = 0; i < 3; i++) begin
      host.cmd(cs[23-8*i -: 8]);
      #1;
      check({busy, cmd_start}, 2'h3);
      check({track_update, head_load, verify_en, step_rate_sel}, es[14-5*i -: 5]);
      host.xfer(1'b1, 8'h00, 32'h00000080);
      tick(1);
      check({track_update, head_load, verify_en, step_rate_sel}, es[14-5*i -: 5]);
      done_cmd();
      rd(8'h04);
      check(host.rd_data[1], 1'b1);
      rd(8'h00);
      check(host.rd_data[7:0], cs[23-8*i -: 8]);
    end
  endtask

  // Sector flags with the compare variant.
  task automatic t_sector();
    logic [23:0] cs;
    logic [32:0] es;
    cs = 24'hBBA092;
    es = {11'h7C7, 11'h7D8, 11'h7DE};
    host.xfer(1'b1, 8'h08, 32'h00000000);
    for (int i = 0; i < 3; i++) begin
      host.cmd(cs[23-8*i -: 8]);
      #1;
      check(cmd_start, 1'b1);
      check({data_mark, multi_record, side_cmp_en, side_cmp_val}, es[32-11*i -: 11]);
      check(side_select_out, 1'b0);
      done_cmd();
    end
  endtask

  // Side-select variant: side output and both length tables.
  task automatic t_side();
    logic [10:0] e;
    host.xfer(1'b1, 8'h08, 32'h00000001);
    for (int l = 0; l < 2; l++) begin
      host.cmd(l ? 8'h8A : 8'h80);
      #1;
      check({side_select_out, side_cmp_en}, {l[0], 1'b0});
      for (int k = 0; k < 4; k++) begin
        @(posedge pclk);
        id_len_code <= k[1:0];
        tick(2);
        e = l ? (11'h080 << k) : ((k == 3) ? 11'h080 : (11'h100 << k));
        check(sector_bytes, e);
      end
      done_cmd();
    end
  endtask

  // Settling delay, normal and slow clock, counted from settle_busy.
  task automatic t_settle();
    int cnt;
    for (int s = 0; s < 2; s++) begin
      host.xfer(1'b1, 8'h08, s ? 32'h00000002 : 32'h00000000);
      host.cmd(8'h84);
      #1;
      cnt = 0;
      for (int n = 0; n < 200 && cmd_start !== 1'b1; n++) begin
        if (settle_busy === 1'b1) cnt++;
        tick(1);
      end
      check(cnt, s ? 40 : 20);
      done_cmd();
    end
  endtask

  // Sector command refused without ready; positioning runs anyway.
  task automatic t_notready();
    @(posedge pclk);
    drive_ready <= 1'b0;
    host.cmd(8'h80);
    tick(1);
    check({busy, intrq}, 2'h1);
    rd(8'h04);
    check(host.rd_data[4], 1'b1);
    host.cmd(8'h10);
    #1;
    check(busy, 1'b1);
    done_cmd();
    @(posedge pclk);
    drive_ready <= 1'b1;
    tick(2);
  endtask

  // Drive one input level at an edge, then judge intrq a few cycles later.
  task automatic ev(input int which, input logic v, input logic exp);
    @(posedge pclk);
    if (which == 0) drive_ready <= v;
    else index_pulse <= v;
    if (which == 1) begin
      @(posedge pclk);
      index_pulse <= 1'b0;
    end
    tick(3);
    check(intrq, exp);
  endtask

  task automatic t_force();
    int n;
    rd(8'h04);
    tick(1);
    check(intrq, 1'b0);
    host.cmd(8'hD8);
    tick(1);
    check(intrq, 1'b1);
    rd(8'h0C);
    check(host.rd_data[3:0], 4'h8);
    host.cmd(8'hD1);
    rd(8'h04);
    ev(0, 1'b0, 1'b0);
    ev(0, 1'b1, 1'b1);
    rd(8'h04);
    ev(0, 1'b0, 1'b0);
    ev(0, 1'b1, 1'b1);
    host.cmd(8'hD2);
    rd(8'h04);
    ev(0, 1'b0, 1'b1);
    rd(8'h04);
    ev(0, 1'b1, 1'b0);
    host.cmd(8'hD4);
    rd(8'h04);
    ev(1, 1'b1, 1'b1);
    rd(8'h04);
    ev(1, 1'b1, 1'b1);
    host.cmd(8'h10);
    host.cmd(8'hD0);
    n = 0;
    repeat (3) begin
      #1;
      if (cmd_abort === 1'b1) n++;
      @(posedge pclk);
    end
    #1;
    check(n, 1);
    check({busy, intrq}, 2'h0);
    ev(1, 1'b1, 1'b0);
  endtask

  // Enable low freezes every flop: a new length code waits until enable returns.
  task automatic t_ce();
    @(posedge pclk);
    ce          <= 1'b0;
    id_len_code <= 2'h0;
    tick(3);
    check(sector_bytes, 11'h080);
    @(posedge pclk);
    ce <= 1'b1;
    tick(2);
    check(sector_bytes, 11'h100);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle limit guards against a hang anywhere in the sequence.
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      results();
    end
  end

  // Main sequence: reset for 20 cycles, then every scenario in turn.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_position();
    t_sector();
    t_side();
    t_settle();
    t_notready();
    t_force();
    t_ce();
    results();
  end
endmodule // tb_top
